//--- pib_pkg.sv
package pib_pkg;

  typedef logic [7:0] pib_byte_t;

  localparam int PIB_ADDR_W = 8;

  // byte offsets on the register bus
  localparam logic [7:0] OFS_EN_GRP4   = 8'h00;
  localparam logic [7:0] OFS_EN_GRP5   = 8'h04;
  localparam logic [7:0] OFS_EN_GRP6   = 8'h08;
  localparam logic [7:0] OFS_PRIO_GRP1 = 8'h0C;
  localparam logic [7:0] OFS_PRIO_GRP2 = 8'h10;
  localparam logic [7:0] OFS_PRIO_GRP3 = 8'h14;
  localparam logic [7:0] OFS_PRIO_GRP4 = 8'h18;
  localparam logic [7:0] OFS_PRIO_GRP5 = 8'h1C;
  localparam logic [7:0] OFS_PRIO_GRP6 = 8'h20;
  localparam logic [7:0] OFS_CTRL      = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;

  // register indexes: storage registers first, then control and status
  localparam int        N_STORE    = 9;
  localparam logic [3:0] IDX_EN_GRP4   = 4'h0;
  localparam logic [3:0] IDX_EN_GRP5   = 4'h1;
  localparam logic [3:0] IDX_EN_GRP6   = 4'h2;
  localparam logic [3:0] IDX_PRIO_GRP1 = 4'h3;
  localparam logic [3:0] IDX_PRIO_GRP2 = 4'h4;
  localparam logic [3:0] IDX_PRIO_GRP3 = 4'h5;
  localparam logic [3:0] IDX_PRIO_GRP4 = 4'h6;
  localparam logic [3:0] IDX_PRIO_GRP5 = 4'h7;
  localparam logic [3:0] IDX_PRIO_GRP6 = 4'h8;
  localparam logic [3:0] IDX_CTRL      = 4'h9;
  localparam logic [3:0] IDX_STATUS    = 4'hA;
  localparam logic [3:0] IDX_NONE      = 4'hF;

  // implemented bits and power-on values, index order as above
  localparam pib_byte_t STORE_MASK [N_STORE] = '{8'hFF, 8'h77, 8'hF7, 8'hFF, 8'hFF,
                                                 8'hFF, 8'hFF, 8'h77, 8'hF7};
  localparam pib_byte_t STORE_RST  [N_STORE] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
                                                 8'hFF, 8'hFF, 8'h77, 8'hF7};
  localparam logic      CTRL_RST        = 1'b0;

  // control and status fields
  localparam int CTRL_LEVELS_BIT = 7;
  localparam int CTRL_GLOBAL_BIT = 6;
  localparam int STAT_HIGH_BIT   = 0;
  localparam int STAT_LOW_BIT    = 1;

  // group 5 and group 6 layouts
  localparam int G5_CLK_RANGE = 6;
  localparam int G5_CLK_LOCK  = 5;
  localparam int G5_TMR8      = 4;
  localparam int G5_TMR6      = 2;
  localparam int G5_TMR5      = 1;
  localparam int G5_TMR4      = 0;
  localparam int G6_SER4_RX   = 7;
  localparam int G6_SER4_TX   = 6;
  localparam int G6_SER3_RX   = 5;
  localparam int G6_SER3_TX   = 4;
  localparam int G6_CMP3      = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

//--- pib_axil_slave.sv
module pib_axil_slave
  import pib_pkg::*;
#(
  parameter int ADDR_W = PIB_ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic              wr_en,
  output      logic [ADDR_W-1:0] wr_addr,
  output      logic [31:0]       wr_data,
  output      logic [3:0]        wr_strb,
  input  wire logic              wr_err,
  output      logic [ADDR_W-1:0] rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // address and data are taken in either order; the write fires once both are held and no response is pending
  assign awready = !aw_held_r;
  assign wready  = !w_held_r;
  assign wr_en   = aw_held_r && w_held_r && !bvalid_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (wr_en) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (wr_en) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_err ? RESP_DECERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // one read in flight; a new address is refused until the data is taken
  assign arready = !rvalid_r;
  assign rd_addr = araddr;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_err ? RESP_DECERR : RESP_OKAY;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // pib_axil_slave

//--- pib_route.sv
module pib_route #(
  parameter int GROUPS = 6
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [GROUPS*8-1:0] flags,
  input  wire logic [GROUPS*8-1:0] enables,
  input  wire logic [GROUPS*8-1:0] prios,
  input  wire logic                levels_on,
  input  wire logic                global_en,
  output      logic                irq_high_r,
  output      logic                irq_low_r
);

  logic [GROUPS-1:0] grp_hi;
  logic [GROUPS-1:0] grp_lo;
  logic              irq_high_nxt;
  logic              irq_low_nxt;

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    logic [7:0] req;
    assign req       = flags[g*8 +: 8] & enables[g*8 +: 8];
    assign grp_hi[g] = |(req & prios[g*8 +: 8]);
    assign grp_lo[g] = |(req & ~prios[g*8 +: 8]);
  end

  always_comb begin
    if (levels_on) begin
      irq_high_nxt = |grp_hi;
      irq_low_nxt  = |grp_lo;
    end else begin
      // single-level mode: priority bits ignored, global enable gates all
      irq_high_nxt = global_en && (|grp_hi || |grp_lo);
      irq_low_nxt  = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_high_r <= 1'b0;
      irq_low_r  <= 1'b0;
    end else begin
      irq_high_r <= irq_high_nxt;
      irq_low_r  <= irq_low_nxt;
    end
  end

endmodule // pib_route

//--- pib_bank.sv
// Function
// - enable bit 1 lets its flag request; 0 masks that source
// - priority bit 1 routes to high request, 0 to low request
// - priority bits act only while priority levels are on
// - six priority registers, groups one to six
// - reset: enable bits clear, priority bits set; all read/write
// - unimplemented bits read zero and ignore writes
// - group-4 bits 7..1 serve channels 10..4, bit 0 enhanced channel 3
// - group-5 layout: clock tuning, timer8, timer6, timer5, timer4
// - group-6 layout: serial ports 4 and 3, comparators 3..1
// - group-1 priority layout: parallel port down to timer-1 overflow
// - group-2 priority layout: oscillator fail down to timer-3 gate
// - group-3 priority layout: timer-5 gate down to calendar clock
// - levels off: peripheral global enable needed before any request
// - priority-levels control in reset control register; clear is single level
//
// Chosen here: register access over AXI4-Lite and the register addresses.
module pib_bank
  import pib_pkg::*;
#(
  parameter int ADDR_W = PIB_ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire logic [7:0]        flag_grp1,
  input  wire logic [7:0]        flag_grp2,
  input  wire logic [7:0]        flag_grp3,
  input  wire logic [7:0]        flag_grp4,
  input  wire logic [7:0]        flag_grp5,
  input  wire logic [7:0]        flag_grp6,
  input  wire logic [7:0]        enable_grp1_in,
  input  wire logic [7:0]        enable_grp2_in,
  input  wire logic [7:0]        enable_grp3_in,
  output      logic              irq_high_req,
  output      logic              irq_low_req,
  output      logic              priority_levels_on,
  output      logic              peripheral_global_enable
);

  pib_byte_t         regs_r [N_STORE];
  logic              levels_on_r;
  logic              global_en_r;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;
  logic [3:0]        wr_idx;
  logic [3:0]        rd_idx;
  logic              wr_lane0;
  logic [47:0]       flags_all;
  logic [47:0]       enables_all;
  logic [47:0]       prios_all;
  logic              irq_high_r;
  logic              irq_low_r;

  // shared by the write and read paths
  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    ofs = 8'(a);
    case (ofs)
      OFS_EN_GRP4:   reg_index = IDX_EN_GRP4;
      OFS_EN_GRP5:   reg_index = IDX_EN_GRP5;
      OFS_EN_GRP6:   reg_index = IDX_EN_GRP6;
      OFS_PRIO_GRP1: reg_index = IDX_PRIO_GRP1;
      OFS_PRIO_GRP2: reg_index = IDX_PRIO_GRP2;
      OFS_PRIO_GRP3: reg_index = IDX_PRIO_GRP3;
      OFS_PRIO_GRP4: reg_index = IDX_PRIO_GRP4;
      OFS_PRIO_GRP5: reg_index = IDX_PRIO_GRP5;
      OFS_PRIO_GRP6: reg_index = IDX_PRIO_GRP6;
      OFS_CTRL:      reg_index = IDX_CTRL;
      OFS_STATUS:    reg_index = IDX_STATUS;
      default:       reg_index = IDX_NONE;
    endcase
  endfunction

  pib_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  assign wr_idx   = reg_index(wr_addr);
  assign rd_idx   = reg_index(rd_addr);
  // status is read-only: a write there is accepted and dropped
  assign wr_err   = (wr_idx == IDX_NONE);
  assign rd_err   = (rd_idx == IDX_NONE);
  // registers are one byte wide; only lane 0 carries them
  assign wr_lane0 = wr_en && wr_strb[0];

  // three enable and six priority registers, one writer each
  for (genvar g = 0; g < N_STORE; g++) begin : g_store
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_r[g] <= STORE_RST[g];
      end else if (wr_lane0 && wr_idx == 4'(g)) begin
        regs_r[g] <= wr_data[7:0] & STORE_MASK[g];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      levels_on_r <= CTRL_RST;
      global_en_r <= CTRL_RST;
    end else if (wr_lane0 && wr_idx == IDX_CTRL) begin
      levels_on_r <= wr_data[CTRL_LEVELS_BIT];
      global_en_r <= wr_data[CTRL_GLOBAL_BIT];
    end
  end

  always_comb begin
    rd_data = '0;
    case (rd_idx)
      IDX_CTRL: begin
        rd_data[CTRL_LEVELS_BIT] = levels_on_r;
        rd_data[CTRL_GLOBAL_BIT] = global_en_r;
      end
      IDX_STATUS: begin
        rd_data[STAT_HIGH_BIT] = irq_high_r;
        rd_data[STAT_LOW_BIT]  = irq_low_r;
      end
      IDX_NONE: rd_data = '0;
      default:  rd_data[7:0] = regs_r[rd_idx];
    endcase
  end

  // bit positions pass straight through: each source keeps its documented slot
  assign flags_all   = {flag_grp6, flag_grp5, flag_grp4,
                        flag_grp3, flag_grp2, flag_grp1};
  assign enables_all = {regs_r[IDX_EN_GRP6], regs_r[IDX_EN_GRP5],
                        regs_r[IDX_EN_GRP4], enable_grp3_in,
                        enable_grp2_in, enable_grp1_in};
  assign prios_all   = {regs_r[IDX_PRIO_GRP6], regs_r[IDX_PRIO_GRP5],
                        regs_r[IDX_PRIO_GRP4], regs_r[IDX_PRIO_GRP3],
                        regs_r[IDX_PRIO_GRP2],
                        regs_r[IDX_PRIO_GRP1]};

  pib_route #(
    .GROUPS (6)
  ) u_route (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .flags      (flags_all),
    .enables    (enables_all),
    .prios      (prios_all),
    .levels_on  (levels_on_r),
    .global_en  (global_en_r),
    .irq_high_r (irq_high_r),
    .irq_low_r  (irq_low_r)
  );

  assign irq_high_req             = irq_high_r;
  assign irq_low_req              = irq_low_r;
  assign priority_levels_on       = levels_on_r;
  assign peripheral_global_enable = global_en_r;

  // checks
  logic [47:0] req_all;
  assign req_all = flags_all & enables_all;

  AST_MASKED_QUIET: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req_all == '0) |=> (!irq_high_req && !irq_low_req))
    else $error("request raised with every source masked");

  AST_ENABLED_FIRES: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (levels_on_r && req_all != '0) |=> (irq_high_req || irq_low_req))
    else $error("enabled flag raised no request");

  AST_HIGH_ROUTE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (levels_on_r && |(req_all & prios_all)) |=> irq_high_req)
    else $error("high priority source not on high line");

  AST_LOW_ROUTE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (levels_on_r && |(req_all & ~prios_all)) |=> irq_low_req)
    else $error("low priority source not on low line");

  AST_LEVELS_OFF_NO_LOW: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !levels_on_r |=> !irq_low_req)
    else $error("low line used while priority levels off");

  AST_GLOBAL_GATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!levels_on_r && !global_en_r) |=> !irq_high_req)
    else $error("request passed with peripheral global enable clear");

  AST_SINGLE_LEVEL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!levels_on_r && global_en_r && req_all != '0) |=> irq_high_req)
    else $error("single-level request not raised");

  AST_RESET_VALUES: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> (regs_r[IDX_EN_GRP4] == 8'h00 && regs_r[IDX_EN_GRP6] == 8'h00
                         && regs_r[IDX_PRIO_GRP1] == 8'hFF
                         && regs_r[IDX_PRIO_GRP6] == 8'hF7 && !levels_on_r))
    else $error("wrong value after reset");

  AST_UNIMP_ZERO: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (regs_r[IDX_EN_GRP5][7] == 1'b0 && regs_r[IDX_EN_GRP5][3] == 1'b0
     && regs_r[IDX_PRIO_GRP5][7] == 1'b0 && regs_r[IDX_PRIO_GRP5][3] == 1'b0
     && regs_r[IDX_EN_GRP6][3] == 1'b0 && regs_r[IDX_PRIO_GRP6][3] == 1'b0))
    else $error("unimplemented bit is set");

  AST_EN4_WRITE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_lane0 && wr_idx == IDX_EN_GRP4) |=> (regs_r[IDX_EN_GRP4] == $past(wr_data[7:0])))
    else $error("group-4 enable write lost");

  AST_GRP5_TIMER8: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (levels_on_r && flag_grp5 == (8'h01 << G5_TMR8) && regs_r[IDX_EN_GRP5][G5_TMR8]
     && !regs_r[IDX_PRIO_GRP5][G5_TMR8] && req_all[23:0] == '0 && req_all[47:40] == '0)
    |=> (irq_low_req && !irq_high_req))
    else $error("timer-8 slot misrouted");

  AST_GRP6_SER4: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_lane0 && wr_idx == IDX_EN_GRP6)
    |=> (regs_r[IDX_EN_GRP6][G6_SER4_RX] == $past(wr_data[G6_SER4_RX])
         && regs_r[IDX_EN_GRP6][G6_CMP3] == $past(wr_data[G6_CMP3])))
    else $error("group-6 enable write lost");

  AST_WRITE_RESP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_en |=> (bvalid && bresp == (wr_err ? RESP_DECERR : RESP_OKAY)))
    else $error("write response missing");

  COV_HIGH: cover property (
    @(posedge aclk) disable iff (!aresetn)
    levels_on_r && irq_high_req);

  COV_LOW: cover property (
    @(posedge aclk) disable iff (!aresetn)
    levels_on_r && irq_low_req);

  COV_SINGLE: cover property (
    @(posedge aclk) disable iff (!aresetn)
    !levels_on_r && global_en_r && irq_high_req);

  COV_DECERR: cover property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid && rresp == RESP_DECERR);

endmodule // pib_bank

//--- pib_src_model.sv
// peripheral flag sources on the far side of the bank; flags are levels held until changed
module pib_src_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       set_en,
  input  wire logic [2:0] set_grp,
  input  wire logic [7:0] set_val,
  output      logic [7:0] flag_grp1,
  output      logic [7:0] flag_grp2,
  output      logic [7:0] flag_grp3,
  output      logic [7:0] flag_grp4,
  output      logic [7:0] flag_grp5,
  output      logic [7:0] flag_grp6
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] flag_r [1:6];

  // group 0 clears every source at once, so one scenario never leaks into the next
  always_ff @(posedge aclk) begin
    if (!aresetn || (set_en && set_grp == 3'h0)) begin
      flag_r <= '{default: 8'h00};
    end else if (set_en && set_grp <= 3'h6) begin
      flag_r[set_grp] <= set_val;
    end
  end

  assign flag_grp1 = flag_r[1];
  assign flag_grp2 = flag_r[2];
  assign flag_grp3 = flag_r[3];
  assign flag_grp4 = flag_r[4];
  assign flag_grp5 = flag_r[5];
  assign flag_grp6 = flag_r[6];
endmodule // pib_src_model

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pib_pkg::*;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, set_en;
  logic [7:0]  awaddr, araddr, set_val, en1, en2, en3;
  logic [7:0]  f1, f2, f3, f4, f5, f6;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [2:0]  set_grp;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq_h, irq_l, lv_on, gl_en;
  int          miscompares, num_checks, cyc;
  // implemented bits per storage register, bus index order
  localparam logic [7:0] IMPL [9] = '{8'hFF, 8'h77, 8'hF7, 8'hFF, 8'hFF,
                                      8'hFF, 8'hFF, 8'h77, 8'hF7};

  pib_bank u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .flag_grp1(f1), .flag_grp2(f2), .flag_grp3(f3), .flag_grp4(f4), .flag_grp5(f5),
    .flag_grp6(f6), .enable_grp1_in(en1), .enable_grp2_in(en2), .enable_grp3_in(en3),
    .irq_high_req(irq_h), .irq_low_req(irq_l), .priority_levels_on(lv_on),
    .peripheral_global_enable(gl_en));

  pib_src_model u_src (.aclk(aclk), .aresetn(aresetn), .set_en(set_en), .set_grp(set_grp),
    .set_val(set_val), .flag_grp1(f1), .flag_grp2(f2), .flag_grp3(f3), .flag_grp4(f4),
    .flag_grp5(f5), .flag_grp6(f6));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hung handshake ends the run here
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // handshakes are judged at the falling edge, where the values equal those of the next rise
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw, wg, bg;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bg = 1'b0;
    // only the bench timeout ends a wait for the response
    while (!bg) begin
      @(negedge aclk);
      aw = awvalid && (awready === 1'b1);
      wg = wvalid && (wready === 1'b1);
      bg = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (wg) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ag, rg;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rg = 1'b0;
    while (!rg) begin
      @(negedge aclk);
      ag = arvalid && (arready === 1'b1);
      rg = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ag) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic set_flag(input logic [2:0] g, input logic [7:0] v);
    @(posedge aclk);
    set_en <= 1'b1;
    set_grp <= g;
    set_val <= v;
    @(posedge aclk);
    set_en <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic reset_vals();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4), d, r);
      chk("reset value", (i < 3) ? 32'h0 : {24'h0, IMPL[i]}, d);
    end
    rd(OFS_CTRL, d, r);
    chk("control reset", 32'h0, d);
  endtask

  task automatic rw_all();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 9; i++) begin
      wr(8'(i * 4), 8'hFF, 4'hF, r);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd(8'(i * 4), d, r);
      chk("ones readback", {24'h0, IMPL[i]}, d);
      wr(8'(i * 4), 8'h00, 4'hF, r);
      rd(8'(i * 4), d, r);
      chk("zeros readback", 32'h0, d);
    end
    // byte lane 0 off: the register must keep its value
    wr(OFS_EN_GRP4, 8'h5A, 4'hE, r);
    rd(OFS_EN_GRP4, d, r);
    chk("masked write", 32'h0, d);
    wr(8'h40, 8'hFF, 4'hF, r);
    chk("unmapped write resp", {30'h0, RESP_DECERR}, {30'h0, r});
    rd(8'h40, d, r);
    chk("unmapped read resp", {30'h0, RESP_DECERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
  endtask

  task automatic route(input int g, input int b, input logic en, input logic pr,
                       input logic [7:0] c, input logic eh, input logic el);
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  m;
    m = en ? (8'h01 << b) : 8'h00;
    wr(OFS_CTRL, c, 4'hF, r);
    if (g == 1) en1 <= m;
    if (g == 2) en2 <= m;
    if (g == 3) en3 <= m;
    if (g > 3) wr(8'((g - 4) * 4), m, 4'hF, r);
    wr(8'(OFS_PRIO_GRP1 + (g - 1) * 4), pr ? 8'hFF : 8'h00, 4'hF, r);
    set_flag(3'(g), 8'h01 << b);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("high request", {31'h0, eh}, {31'h0, irq_h});
    chk("low request", {31'h0, el}, {31'h0, irq_l});
    chk("levels out", {31'h0, c[7]}, {31'h0, lv_on});
    chk("global out", {31'h0, c[6]}, {31'h0, gl_en});
    rd(OFS_STATUS, d, r);
    chk("status", {30'h0, el, eh}, d);
    set_flag(3'h0, 8'h00);
  endtask

  task automatic route_all();
    int bits [6] = '{7, 7, 0, 0, 6, 7};
    for (int g = 1; g <= 6; g++) begin
      route(g, bits[g-1], 1'b1, 1'b1, 8'h80, 1'b1, 1'b0);
      route(g, bits[g-1], 1'b1, 1'b0, 8'h80, 1'b0, 1'b1);
      route(g, bits[g-1], 1'b0, 1'b1, 8'h80, 1'b0, 1'b0);
      route(g, bits[g-1], 1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
      route(g, bits[g-1], 1'b1, 1'b0, 8'h40, 1'b1, 1'b0);
    end
  endtask

  // flags on missing group-5 positions must never reach a request line
  task automatic unimpl();
    logic [1:0] r;
    wr(OFS_CTRL, 8'hC0, 4'hF, r);
    wr(OFS_EN_GRP5, 8'hFF, 4'hF, r);
    set_flag(3'h5, 8'h88);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("unimpl high", 32'h0, {31'h0, irq_h});
    chk("unimpl low", 32'h0, {31'h0, irq_l});
    set_flag(3'h0, 8'h00);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, set_en} = 6'h00;
    {awaddr, araddr, set_val, en1, en2, en3} = 48'h0;
    {wdata, wstrb, set_grp} = 39'h0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    reset_vals();
    rw_all();
    route_all();
    unimpl();
    do_reset();
    reset_vals();
    finish_test();
  end
endmodule // tb_top
